//--- src/lrc_ladder_reference_control.sv
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "lrc_defs.svh"

// Contract
// - Drive a ladder of 16 selectable taps with a power-down control.
// - Enable bit 7 powers the ladder on when 1 and down when 0.
// - Range bit 5 picks the low range (code/24) at 1 and high range (1/4 plus code/32) at 0.
// - The 4-bit level field in bits 3..0 takes codes 0 to 15, sixteen levels per range.
// - In the low range, source bit 4 picks external reference at 1 and analog supply at 0.
// - In the high range, source bit 4 at 1 bypasses to the external reference, at 0 no reference.
// - Reference choice: both 0 none, enable 0 source 1 bypass, enable 1 ladder output.
// - Bit 6 ignores writes and reads back as zero.
// - Wake-up from sleep leaves the control register unchanged.
// - Reset clears enable, range and level, leaving the reference powered down.
module lrc_ladder_reference_control
    import lrc_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Sleep state, informational only
    input wire logic sleepActive,
    // AXI4-Lite write address
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog switch controls
    output logic ladderPowerOn,
    output logic ladderSupplyExternal,
    output logic ladderRangeLow,
    output logic [15:0] ladderTapSelect,
    output logic comparatorRefLadder,
    output logic comparatorRefBypass
);

    ////////////////////////////////////////////////////////////////////////////
    // Register map, one 32-bit word each
    //   0x000  control byte in bits 7:0, upper bits read zero
    //          bit 7 ladder power, bit 6 unused,
    //          bit 5 low range, bit 4 source select,
    //          bits 3:0 tap code
    //   0x004  read-only switch status
    //          bits 23:8 tap one-hot, bit 3 power,
    //          bit 2 external supply, bits 1:0 reference source
    //   other  slave error, no effect
    //
    // Write timing
    //   edge 1  address and data taken, readies drop
    //   edge 2  both halves held: byte stored, response raised
    //   edge 3  switch controls follow the stored byte
    //   readies come back on the response handshake edge
    //
    // Read timing
    //   edge 1  address taken, data and response registered
    //   ready comes back on the data handshake edge
    //
    // Partial strobes
    //   only byte lane 0 carries the control byte, so a write
    //   without it is answered but changes nothing
    //
    // Limitation
    //   one write and one read in flight; a second request
    //   waits for its ready, which keeps the slave small

    ////////////////////////////////////////////////////////////////////////////
    // State
    lrc_state_s state_q;
    lrc_state_s state_d;
    logic [7:0] ctrlByte;
    logic [7:0] newByte;
    logic doWrite;
    logic [ADDR_WIDTH-1:0] wrAddr;
    logic [15:0] tapDecode;

    // Control register as software sees it; bit 6 always zero
    // Built from the stored fields rather than kept as a byte,
    // so the unused bit has no flip-flop that could ever read
    // back as one after a stray write
    always_comb begin
        ctrlByte = 8'h00;
        ctrlByte[`LRC_ENABLE_BIT] = state_q.ctrl.enable;
        ctrlByte[`LRC_RANGE_BIT] = state_q.ctrl.rangeLow;
        ctrlByte[`LRC_SOURCE_BIT] = state_q.ctrl.sourceSel;
        ctrlByte[`LRC_LEVEL_MSB:`LRC_LEVEL_LSB] = state_q.ctrl.level;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tap decode, one comparator per tap
    // A tap may only close while the ladder is powered,
    // so a powered-down ladder never leaks through a switch
    for (genvar tapIdx = 0; tapIdx < `LRC_TAP_COUNT; tapIdx++) begin : g_tap
        assign tapDecode[tapIdx] = state_q.ctrl.enable && (state_q.ctrl.level == 4'(tapIdx));
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        state_d = state_q;
        doWrite = 1'b0;
        newByte = ctrlByte;
        wrAddr = '0;

        // Capture address and data separately, in either order
        // Each ready drops on its own take, so a master that
        // offers one half early is simply held off on that
        // same half until the response has been accepted
        if (s_axi_awvalid && state_q.bus.awready) begin
            state_d.bus.awHeld = 1'b1;
            state_d.bus.awAddr = 12'(s_axi_awaddr);
            state_d.bus.awready = 1'b0;
        end
        if (s_axi_wvalid && state_q.bus.wready) begin
            state_d.bus.wHeld = 1'b1;
            state_d.bus.wData = s_axi_wdata;
            state_d.bus.wStrb = s_axi_wstrb;
            state_d.bus.wready = 1'b0;
        end

        // Both halves held: commit and answer
        // Committing one edge after the take keeps the decode
        // off the bus inputs, at the cost of one extra cycle
        // The held flags clear here, so a waiting response
        // can never commit the same beat twice
        if (state_q.bus.awHeld && state_q.bus.wHeld && !state_q.bus.bvalid) begin
            wrAddr = ADDR_WIDTH'(state_q.bus.awAddr);
            state_d.bus.bvalid = 1'b1;
            state_d.bus.awHeld = 1'b0;
            state_d.bus.wHeld = 1'b0;
            if ({wrAddr[ADDR_WIDTH-1:2], 2'b00} == ADDR_WIDTH'(`LRC_CTRL_ADDR)) begin
                state_d.bus.bresp = `LRC_RESP_OKAY;
                doWrite = state_q.bus.wStrb[0];
            end else if ({wrAddr[ADDR_WIDTH-1:2], 2'b00} == ADDR_WIDTH'(`LRC_STATUS_ADDR)) begin
                // Read-only status: write ignored, still OKAY
                state_d.bus.bresp = `LRC_RESP_OKAY;
            end else begin
                state_d.bus.bresp = `LRC_RESP_SLVERR;
            end
        end
        if (state_q.bus.bvalid && s_axi_bready) begin
            state_d.bus.bvalid = 1'b0;
            state_d.bus.awready = 1'b1;
            state_d.bus.wready = 1'b1;
        end

        // Register write; bit 6 dropped by the mask
        // All fields change together in one edge, so the
        // switch decode never sees a half-written byte
        if (doWrite) begin
            newByte = state_q.bus.wData[7:0] & `LRC_CTRL_WMASK;
            state_d.ctrl.enable = newByte[`LRC_ENABLE_BIT];
            state_d.ctrl.rangeLow = newByte[`LRC_RANGE_BIT];
            state_d.ctrl.sourceSel = newByte[`LRC_SOURCE_BIT];
            state_d.ctrl.level = newByte[`LRC_LEVEL_MSB:`LRC_LEVEL_LSB];
        end
        // Sleep does not touch the control fields, only reset does
        // Software is expected to drop the power bit before sleep
        // if the ladder current matters; the block does not do it
        // for them, since a wake-up must find the byte untouched


        // Read channel: one outstanding read
        // Read data is captured on the address edge, so a
        // slow master sees the value of that moment, not a
        // later one, while the data stays on the bus
        if (s_axi_arvalid && state_q.bus.arready) begin
            state_d.bus.arready = 1'b0;
            state_d.bus.rvalid = 1'b1;
            state_d.bus.rresp = `LRC_RESP_OKAY;
            state_d.bus.rdata = 32'h0000_0000;
            if ({s_axi_araddr[ADDR_WIDTH-1:2], 2'b00} == ADDR_WIDTH'(`LRC_CTRL_ADDR)) begin
                state_d.bus.rdata = {24'h00_0000, ctrlByte};
            end else if ({s_axi_araddr[ADDR_WIDTH-1:2], 2'b00} == ADDR_WIDTH'(`LRC_STATUS_ADDR)) begin
                // Live switch state for software
                state_d.bus.rdata = {8'h00, state_q.sw.tapSelect, 4'h0, state_q.sw.ladderPower,
                    state_q.sw.supplyExternal, state_q.sw.refSource};
            end else begin
                state_d.bus.rresp = `LRC_RESP_SLVERR;
            end
        end
        if (state_q.bus.rvalid && s_axi_rready) begin
            state_d.bus.rvalid = 1'b0;
            state_d.bus.arready = 1'b1;
        end

        // Decode stored fields into switch controls, one edge after the write
        state_d.sw.ladderPower = state_q.ctrl.enable;
        state_d.sw.rangeLow = state_q.ctrl.rangeLow;
        state_d.sw.supplyExternal = state_q.ctrl.rangeLow & state_q.ctrl.sourceSel;
        state_d.sw.tapSelect = tapDecode;

        // Reference source: ladder wins whenever powered
        // One code drives both comparator selects, so the
        // ladder and the bypass path can never be on together
        // Low range with the ladder off still bypasses, as the
        // enable and source table asks
        if (state_q.ctrl.enable) begin
            state_d.sw.refSource = LRC_REF_LADDER;
        end else if (state_q.ctrl.sourceSel && !state_q.ctrl.rangeLow) begin
            state_d.sw.refSource = LRC_REF_BYPASS;
        end else if (state_q.ctrl.sourceSel) begin
            // Low range with ladder off: treated as bypass per enable/source table
            state_d.sw.refSource = LRC_REF_BYPASS;
        end else begin
            state_d.sw.refSource = LRC_REF_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    // Reset is synchronous and clears the whole state first,
    // then raises the readies so the bus is accepting at once
    // The reference code resets to none, which leaves both
    // comparator selects low and the ladder powered down
    // No other event clears the fields: sleep and wake-up
    // pass through untouched
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= '0;
            state_q.bus.awready <= 1'b1;
            state_q.bus.wready <= 1'b1;
            state_q.bus.arready <= 1'b1;
            state_q.sw.refSource <= LRC_REF_NONE;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    // The two comparator selects are compares of one
    // registered code; they are glitch-free because the code
    // holds at most one of the two values at any time
    // Everything else is a plain wire from a state bit
    assign s_axi_awready = state_q.bus.awready;
    assign s_axi_wready = state_q.bus.wready;
    assign s_axi_bvalid = state_q.bus.bvalid;
    assign s_axi_bresp = state_q.bus.bresp;
    assign s_axi_arready = state_q.bus.arready;
    assign s_axi_rvalid = state_q.bus.rvalid;
    assign s_axi_rresp = state_q.bus.rresp;
    assign s_axi_rdata = state_q.bus.rdata;
    assign ladderPowerOn = state_q.sw.ladderPower;
    assign ladderSupplyExternal = state_q.sw.supplyExternal;
    assign ladderRangeLow = state_q.sw.rangeLow;
    assign ladderTapSelect = state_q.sw.tapSelect;
    assign comparatorRefLadder = (state_q.sw.refSource == LRC_REF_LADDER);
    assign comparatorRefBypass = (state_q.sw.refSource == LRC_REF_BYPASS);


    // Sleep input is observed nowhere: the register simply holds through sleep
    // Kept as a port so the block can later gate its clock
    // without a change to the instance
    logic unusedSleep;
    assign unusedSleep = sleepActive;

endmodule : lrc_ladder_reference_control

`default_nettype wire

//--- src/lrc_defs.svh
`ifndef LRC_DEFS_SVH
`define LRC_DEFS_SVH

// Register byte addresses
`define LRC_CTRL_ADDR 12'h000
`define LRC_STATUS_ADDR 12'h004

// Control register fields
`define LRC_ENABLE_BIT 7
`define LRC_UNUSED_BIT 6
`define LRC_RANGE_BIT 5
`define LRC_SOURCE_BIT 4
`define LRC_LEVEL_MSB 3
`define LRC_LEVEL_LSB 0

// Reset values and masks
`define LRC_CTRL_RESET 8'h00
`define LRC_CTRL_WMASK 8'hBF
`define LRC_TAP_COUNT 16

// Bus response codes
`define LRC_RESP_OKAY 2'h0
`define LRC_RESP_SLVERR 2'h2

`endif

//--- src/lrc_pkg.sv
package lrc_pkg;

    // Stored control fields
    typedef struct packed {
        logic enable;
        logic rangeLow;
        logic sourceSel;
        logic [3:0] level;
    } lrc_ctrl_s;

    // Source of the comparator reference
    typedef enum logic [1:0] {
        LRC_REF_NONE,
        LRC_REF_BYPASS,
        LRC_REF_LADDER
    } lrc_ref_e;

    // Analog switch controls toward the ladder
    typedef struct packed {
        logic ladderPower;
        logic supplyExternal;
        logic rangeLow;
        logic [15:0] tapSelect;
        lrc_ref_e refSource;
    } lrc_switch_s;

    // Bus slave handshake state
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic awHeld;
        logic [11:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
    } lrc_bus_s;

    // Whole module state
    typedef struct packed {
        lrc_bus_s bus;
        lrc_ctrl_s ctrl;
        lrc_switch_s sw;
    } lrc_state_s;

endpackage : lrc_pkg

//--- verification/lrc_properties.sv
`timescale 1ns/100ps
`default_nettype none
module lrc_properties (
    // Clock, reset, sleep
    input wire logic mclk,
    input wire logic rst,
    input wire logic sleepActive,
    // Bus
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    // Switches
    input wire logic ladderPowerOn,
    input wire logic ladderRangeLow,
    input wire logic [15:0] ladderTapSelect,
    input wire logic comparatorRefLadder,
    input wire logic comparatorRefBypass
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Byte of the last data beat; no second beat can land before the check
    logic [7:0] wCap_q;
    always_ff @(posedge mclk) begin
        if (s_axi_wvalid && s_axi_wready) begin
            wCap_q <= s_axi_wdata[7:0];
        end
    end
    ////////////////////////////////////////
    // Write steps
    sequence s_wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_ctrlWrite;
        s_wrTaken ##0 (s_axi_awaddr == 12'h000 && s_axi_wstrb[0]);
    endsequence
    property p_wrResp;
        s_wrTaken |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    a_wrResp: assert property (p_wrResp) else $error("late write response");
    property p_apply;
        s_ctrlWrite |-> ##3 ladderPowerOn == wCap_q[7] && ladderRangeLow == wCap_q[5]
            && comparatorRefBypass == (!wCap_q[7] && wCap_q[4]);
    endproperty
    a_apply: assert property (p_apply) else $error("switches not applied");
    property p_tapOff;
        !ladderPowerOn |-> ladderTapSelect == 16'h0000;
    endproperty
    a_tapOff: assert property (p_tapOff) else $error("tap on while off");
    property p_tapHot;
        ladderPowerOn |-> $onehot(ladderTapSelect);
    endproperty
    a_tapHot: assert property (p_tapHot) else $error("tap not one-hot");
    property p_refLadder;
        comparatorRefLadder == ladderPowerOn && !(comparatorRefLadder && comparatorRefBypass);
    endproperty
    a_refLadder: assert property (p_refLadder) else $error("bad reference pick");
    property p_reset;
        $fell(rst) |-> !ladderPowerOn && !ladderRangeLow && !comparatorRefBypass;
    endproperty
    a_reset: assert property (p_reset) else $error("reset left switches");
    property p_bit6;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_rdata[6];
    endproperty
    a_bit6: assert property (p_bit6) else $error("bit 6 read as one");
    property p_sleep;
        sleepActive && s_axi_awready |=> $stable(ladderPowerOn) && $stable(ladderTapSelect);
    endproperty
    a_sleep: assert property (p_sleep) else $error("switches moved in sleep");
endmodule : lrc_properties
bind lrc_ladder_reference_control lrc_properties chk_u (.*);
`default_nettype wire

//--- verification/lrc_ladder_model.sv
`timescale 1ns/100ps
`default_nettype none
module lrc_ladder_model (
    // Switches
    input wire logic ladderPowerOn,
    input wire logic ladderRangeLow,
    input wire logic [15:0] ladderTapSelect,
    input wire logic comparatorRefBypass,
    // Level in 96ths of the span, FF for the raw external input
    output logic [7:0] refLevel
);
    // Ladder level from the one tap that is closed
    always_comb begin
        refLevel = comparatorRefBypass ? 8'hFF : 8'h00;
        for (int i = 0; i < 16; i++) begin
            if (ladderPowerOn && ladderTapSelect[i]) begin
                refLevel = ladderRangeLow ? 8'(i * 4) : 8'(24 + i * 3);
            end
        end
    end
endmodule : lrc_ladder_model
`default_nettype wire

//--- verification/lrc_ladder_reference_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
module lrc_ladder_reference_control_bench;
    logic mclk, rst, sleepActive, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic ladderPowerOn, ladderSupplyExternal, ladderRangeLow, comparatorRefLadder, comparatorRefBypass;
    logic [15:0] ladderTapSelect;
    logic [7:0] refLevel, c;
    int err_count, check_count;
    lrc_ladder_reference_control dut_u (.*);
    lrc_ladder_model model_u (.*);
    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    ////////////////////////////////////////
    task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : check_val
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    // Bounded edge wait; a hang ends the run as a mismatch
    task automatic tick(inout int n);
        @(posedge mclk);
        n++;
        if (n > 40) begin
            err_count++;
            final_report();
        end
    endtask : tick
    task automatic bus_write(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
        int n = 0;
        tick(n);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'(32'($urandom)), d};
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            tick(n);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : bus_write
    task automatic bus_read(input logic [11:0] a);
        int n = 0;
        tick(n);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            tick(n);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        {rd, rs} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask : bus_read
    // Register, switches and level expected from the stored byte
    task automatic check_all(input logic [7:0] v);
        bus_read(12'h000);
        check_val("ctrl", {24'h0, v}, rd);
        check_val("switches", {11'h0, v[7], v[5] & v[4], v[5], v[7], ~v[7] & v[4], v[7] ? 16'h0001 << v[3:0] : 16'h0000},
            {11'h0, ladderPowerOn, ladderSupplyExternal, ladderRangeLow, comparatorRefLadder, comparatorRefBypass,
            ladderTapSelect});
        check_val("level", v[7] ? (v[5] ? 32'(v[3:0] * 4) : 32'(24 + v[3:0] * 3)) : (v[4] ? 32'hFF : 32'h0),
            {24'h0, refLevel});
        bus_read(12'h004);
        check_val("status", {8'h0, v[7] ? 16'h0001 << v[3:0] : 16'h0000, 4'h0, v[7], v[5] & v[4],
            v[7] ? 2'h2 : {1'b0, v[4]}}, rd);
    endtask : check_all
    ////////////////////////////////////////
    // Main sequence
    initial begin
        {sleepActive, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {err_count, check_count} = '0;
        rst = 1'b1;
        void'($urandom(32'hA31CC9B1));
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        check_all(8'h00);
        // Every code in both ranges, source and bit 6 random
        for (int i = 0; i < 32; i++) begin
            c = {1'b1, 1'($urandom), i[4], 1'($urandom), i[3:0]};
            bus_write(12'h000, c, 4'hF);
            check_all(c & 8'hBF);
        end
        // Enable and source table in both ranges
        for (int i = 0; i < 8; i++) begin
            c = {i[2], 1'b0, i[1], i[0], 4'($urandom)};
            bus_write(12'h000, c, 4'hF);
            check_all(c);
        end
        // Unmapped, read-only and lane-0-strobe-less writes change nothing
        bus_write(12'h008, 8'h00, 4'hF);
        check_val("bresp", 32'h2, {30'h0, rs});
        bus_write(12'h004, 8'h00, 4'hF);
        bus_write(12'h000, 8'h00, 4'hE);
        check_all(c);
        bus_read(12'hFFC);
        check_val("rresp", 32'h2, {30'h0, rs});
        // Enable dropped before sleep, then sleep and wake
        c = c & 8'h7F;
        bus_write(12'h000, c, 4'hF);
        sleepActive <= 1'b1;
        repeat (20) @(posedge mclk);
        sleepActive <= 1'b0;
        check_all(c);
        // Reset in mid-run
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        check_all(8'h00);
        final_report();
    end
endmodule : lrc_ladder_reference_control_bench
`default_nettype wire
